// ==== cmpi_pkg.sv ====
// Purpose: Constants and types for the comparator change interrupt block.
// Assumes: One 10 MHz clock, synchronous active-high reset, plain register port.
// Notes: Register offsets are byte indices on an 8-bit data path.
`default_nettype none

package cmpi_pkg;
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_FLAGS = 3'h1;
    localparam logic [2:0] ADDR_ENABLES = 3'h2;
    localparam logic [2:0] ADDR_IRQ_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_PORT = 3'h4;
    localparam logic [2:0] ADDR_DIRECTION = 3'h5;
    localparam logic [2:0] ADDR_PORT_OUT = 3'h6;

    localparam int RES_LSB = 6;
    localparam int SWITCH_BIT = 3;
    localparam int FLAG_BIT = 0;
    localparam int GIE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'h0f;
    localparam logic [4:0] DIRECTION_RESET = 5'h1f;

    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [2:0] MODE_INTREF = 3'h2;
    localparam logic [2:0] MODE_PIN_OUT = 3'h6;
    localparam logic [2:0] MODE_OFF = 3'h7;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cmpi_bus_s;

    typedef struct packed {
        logic [4:0] out;
        logic [4:0] oe;
    } cmpi_pins_s;

    typedef struct packed {
        logic power_first;
        logic power_second;
        logic intref_to_plus;
        logic switch_sel;
        logic [2:0] mode;
    } cmpi_analog_s;

    // Pins 0..3 are comparator inputs, only 0..2 in mode 110 and 0..1 in mode 101; 3..4 take outputs in mode 110.
    function automatic logic [4:0] analog_mask(input logic [2:0] mode);
        logic [4:0] m;
        m = 5'h00;
        case (mode)
            3'h0: m = 5'h0f;
            3'h7: m = 5'h0f;
            3'h2: m = 5'h0f;
            3'h6: m = 5'h07;
            3'h5: m = 5'h03;
            default: m = 5'h0f;
        endcase
        return m;
    endfunction
endpackage

`default_nettype wire

// ==== cmpi_sync.sv ====
// Purpose: Two-flop synchroniser for the comparator result bits.
// Assumes: Inputs are asynchronous to clk.
// Notes: Only the second stage is visible outside.
`default_nettype none

module cmpi_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);
    logic [1:0] stage1_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            stage1_reg <= 2'h0;
            sync_out <= 2'h0;
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end
endmodule

`default_nettype wire

// ==== cmpi_top.sv ====
// Purpose: Control side of a dual comparator with a change interrupt.
// Assumes: Analog results arrive asynchronously; pins are synchronised here.
// Notes: The raw pin path in mode 110 deliberately bypasses the clock.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`default_nettype none

module cmpi_top (
    input wire logic clk,
    input wire logic srst,
    input wire cmpi_pkg::cmpi_bus_s bus,
    output logic [7:0] rdata,
    input wire logic [1:0] compare_raw,
    input wire logic [4:0] pin_in,
    input wire logic sleeping,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    output cmpi_pkg::cmpi_analog_s analog,
    output logic irq,
    output logic wake
);
    logic [1:0] result_sync;
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [3:0] control_reg;
    logic [1:0] latched_reg;
    logic flag_reg;
    logic enable_reg;
    logic [1:0] global_reg;
    logic [4:0] direction_reg;
    logic [4:0] port_reg;
    logic ctrl_access;
    logic mismatch;
    logic [2:0] mode;
    logic [7:0] rdata_next;

    cmpi_sync u_sync (
        .clk(clk),
        .srst(srst),
        .async_in(compare_raw),
        .sync_out(result_sync)
    );

    assign mode = control_reg[2:0];
    assign ctrl_access = (bus.wr || bus.rd) && bus.addr == cmpi_pkg::ADDR_CONTROL;
    assign mismatch = result_sync != latched_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_s1_reg <= 5'h00;
            pin_s2_reg <= 5'h00;
        end else begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Control bits; sleep has no path here, so waking leaves them as they were.
    always_ff @(posedge clk) begin
        if (srst) begin
            control_reg <= cmpi_pkg::CONTROL_RESET[3:0];
        end else if (bus.wr && bus.addr == cmpi_pkg::ADDR_CONTROL) begin
            control_reg <= bus.wdata[3:0] & cmpi_pkg::CONTROL_WMASK[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            latched_reg <= 2'h0;
        end else if (ctrl_access) begin
            latched_reg <= result_sync;
        end
    end

    // Set by mismatch or a write of one; a clear loses to a set in the same cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_reg <= 1'b0;
        end else if (mismatch && !ctrl_access) begin
            flag_reg <= 1'b1;
        end else if (bus.wr && bus.addr == cmpi_pkg::ADDR_FLAGS) begin
            if (bus.wdata[cmpi_pkg::FLAG_BIT]) begin
                flag_reg <= 1'b1;
            end else begin
                flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            enable_reg <= 1'b0;
        end else if (bus.wr && bus.addr == cmpi_pkg::ADDR_ENABLES) begin
            enable_reg <= bus.wdata[cmpi_pkg::FLAG_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            global_reg <= 2'h0;
        end else if (bus.wr && bus.addr == cmpi_pkg::ADDR_IRQ_CONTROL) begin
            global_reg <= {bus.wdata[cmpi_pkg::GIE_BIT], bus.wdata[cmpi_pkg::PERIPHERAL_IRQ_ENABLE_BIT]};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            direction_reg <= cmpi_pkg::DIRECTION_RESET;
        end else if (bus.wr && bus.addr == cmpi_pkg::ADDR_DIRECTION) begin
            direction_reg <= bus.wdata[4:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            port_reg <= 5'h00;
        end else if (bus.wr && bus.addr == cmpi_pkg::ADDR_PORT_OUT) begin
            port_reg <= bus.wdata[4:0];
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        if (bus.addr == cmpi_pkg::ADDR_CONTROL) begin
            rdata_next = {result_sync, 2'h0, control_reg};
        end else if (bus.addr == cmpi_pkg::ADDR_FLAGS) begin
            rdata_next = {7'h00, flag_reg};
        end else if (bus.addr == cmpi_pkg::ADDR_ENABLES) begin
            rdata_next = {7'h00, enable_reg};
        end else if (bus.addr == cmpi_pkg::ADDR_IRQ_CONTROL) begin
            rdata_next = {global_reg, 6'h00};
        end else if (bus.addr == cmpi_pkg::ADDR_PORT) begin
            rdata_next = {3'h0, pin_s2_reg & ~cmpi_pkg::analog_mask(mode)};
        end else if (bus.addr == cmpi_pkg::ADDR_DIRECTION) begin
            rdata_next = {3'h0, direction_reg};
        end else if (bus.addr == cmpi_pkg::ADDR_PORT_OUT) begin
            rdata_next = {3'h0, port_reg};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            rdata <= rdata_next;
        end else begin
            rdata <= 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq <= flag_reg && enable_reg && global_reg[0] && global_reg[1];
            wake <= sleeping && flag_reg && enable_reg;
        end
    end

    // Port drivers are registered; in mode 110 the raw results replace pins 3 and 4 at the pad.
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_out <= 5'h00;
            pin_oe <= 5'h00;
        end else begin
            pin_out <= port_reg;
            pin_oe <= ~direction_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            analog <= '0;
        end else begin
            analog.power_first <= mode != cmpi_pkg::MODE_OFF && mode != cmpi_pkg::MODE_RESET;
            analog.power_second <= mode != cmpi_pkg::MODE_OFF && mode != cmpi_pkg::MODE_RESET;
            analog.intref_to_plus <= mode == cmpi_pkg::MODE_INTREF;
            analog.switch_sel <= control_reg[cmpi_pkg::SWITCH_BIT];
            analog.mode <= mode;
        end
    end
endmodule

`default_nettype wire

// ==== cmpi_top_monitor.sv ====
// Purpose: Port assertions for cmpi_top.
// Assumes: One clock, srst synchronous.
// Notes: Bound by the statement at the foot.
`default_nettype none
module cmpi_top_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire cmpi_pkg::cmpi_bus_s bus,
    input wire logic [7:0] rdata,
    input wire logic [1:0] compare_raw,
    input wire logic sleeping,
    input wire cmpi_pkg::cmpi_analog_s analog,
    input wire logic irq,
    input wire logic wake
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_reset_quiet: assert property ($fell(srst) |-> analog == '0 && !irq)
        else $error("active after reset");
    a_unused_zero: assert property (bus.rd && bus.addr == 3'h0 |=> rdata[5:4] == 2'h0)
        else $error("unused bits set");
    a_mode_follow: assert property (bus.wr && bus.addr == 3'h0 |=> ##1 analog.mode == $past(bus.wdata[2:0], 2))
        else $error("mode not applied");
    a_power_off: assert property (analog.mode == 3'h7 |-> !analog.power_first && !analog.power_second)
        else $error("powered in off mode");
    a_intref_sel: assert property (analog.intref_to_plus == (analog.mode == 3'h2))
        else $error("reference select wrong");
    a_wake_sleep: assert property (wake |-> $past(sleeping))
        else $error("wake while awake");
    a_result_read: assert property (bus.rd && bus.addr == 3'h0 && $stable(compare_raw)
        && compare_raw == $past(compare_raw, 2) && !$past(srst) && !$past(srst, 2) |=> rdata[7:6] == $past(compare_raw))
        else $error("result bits wrong");
    a_irq_sticky: assert property ($fell(irq) |-> $past(bus.wr, 2) || $past(srst))
        else $error("irq dropped unasked");
    c_irq: cover property (irq);
    c_wake: cover property (wake);
    c_pin_mode: cover property (analog.mode == 3'h6);
endmodule
bind cmpi_top cmpi_top_monitor cmpi_top_monitor_inst (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
    .compare_raw(compare_raw), .sleeping(sleeping), .analog(analog), .irq(irq), .wake(wake));
`default_nettype wire

// ==== cmpi_pads.sv ====
// Purpose: Model of the comparator inputs and port pins.
// Assumes: Inverting inputs sit at mid scale.
// Notes: Undriven pins are pulled up.
`default_nettype none
module cmpi_pads (
    input wire logic [15:0] vin_plus,
    input wire cmpi_pkg::cmpi_analog_s analog,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    output logic [1:0] compare_raw,
    output logic [4:0] pin_in
);
    assign compare_raw[0] = analog.power_first && vin_plus[7:0] > 8'h80;
    assign compare_raw[1] = analog.power_second && vin_plus[15:8] > 8'h80;
    assign pin_in = ~pin_oe | (pin_oe & {analog.mode == 3'h6 ? compare_raw : pin_out[4:3], pin_out[2:0]});
endmodule
`default_nettype wire

// ==== cmpi_top_test.sv ====
// Purpose: Self-checking bench for cmpi_top.
// Assumes: cmpi_pads stands in for the pins.
// Notes: A seeded xorshift picks levels.
`default_nettype none
module cmpi_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, sleeping = 1'b0, irq, wake;
    cmpi_pkg::cmpi_bus_s bus = '0;
    cmpi_pkg::cmpi_analog_s analog;
    logic [7:0] rdata;
    logic [1:0] raw;
    logic [4:0] pin_in, pin_out, pin_oe;
    logic [15:0] vin_plus = 16'h0000;
    logic [31:0] seed = 32'h0000001b;
    int errors = 0, num_checks = 0;
    cmpi_top cmpi_top_inst (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .compare_raw(raw), .pin_in(pin_in),
        .sleeping(sleeping), .pin_out(pin_out), .pin_oe(pin_oe), .analog(analog), .irq(irq), .wake(wake));
    cmpi_pads cmpi_pads_inst (.vin_plus(vin_plus), .analog(analog), .pin_out(pin_out), .pin_oe(pin_oe),
        .compare_raw(raw), .pin_in(pin_in));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    // Comparators are off in modes 000 and 111; the reference feeds both plus inputs in mode 010.
    function automatic logic [7:0] exp_analog(input logic [2:0] m, input logic s);
        logic p;
        p = m != cmpi_pkg::MODE_OFF && m != cmpi_pkg::MODE_RESET;
        return {1'b0, p, p, m == cmpi_pkg::MODE_INTREF, s, m};
    endfunction
    // Pins that the mode makes analog read as zero; pin 4 is always digital.
    function automatic logic [7:0] exp_port(input logic [2:0] m, input logic [4:0] pins);
        logic [4:0] k;
        k = 5'h0f;
        if (m == cmpi_pkg::MODE_PIN_OUT) begin
            k = 5'h07;
        end else if (m == 3'h5) begin
            k = 5'h03;
        end
        return {3'h0, pins & ~k};
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // A write when w is high, else a read whose data must equal d.
    task automatic io(input logic w, input logic [2:0] a, input logic [7:0] d, input string n);
        @(posedge clk);
        bus <= '{a, d, w, !w};
        @(posedge clk);
        bus <= '0;
        if (!w) #1 chk(n, d, rdata);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial forever #50 clk = ~clk;
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        #1 chk("analog", 8'h00, {1'b0, analog});
        io(1'b0, 3'h0, 8'h00, "ctl");
        io(1'b0, 3'h4, 8'h10, "port");
        for (int m = 0; m < 8; m++) begin
            seed = xs(seed);
            io(1'b1, 3'h0, {4'h0, seed[0], m[2:0]}, "");
            io(1'b0, 3'h0, {4'h0, seed[0], m[2:0]}, "ctl");
            chk("analog", exp_analog(m[2:0], seed[0]), {1'b0, analog});
            io(1'b0, 3'h4, exp_port(m[2:0], 5'h1f), "port");
        end
        io(1'b1, 3'h0, 8'hff, "");
        io(1'b0, 3'h0, 8'h0f, "ctl");
        $display("modes done");
        io(1'b1, 3'h0, 8'h03, "");
        io(1'b1, 3'h2, 8'h01, "");
        io(1'b1, 3'h3, 8'hc0, "");
        io(1'b0, 3'h0, 8'h03, "ctl");
        io(1'b1, 3'h1, 8'h00, "");
        io(1'b0, 3'h1, 8'h00, "flag");
        @(posedge clk);
        vin_plus[7:0] <= 8'h81 + {2'h0, seed[5:0]};
        repeat (6) @(posedge clk);
        io(1'b0, 3'h1, 8'h01, "flag");
        chk("irq", 8'h01, {7'h0, irq});
        io(1'b1, 3'h1, 8'h00, "");
        io(1'b0, 3'h1, 8'h01, "flag");
        io(1'b0, 3'h0, 8'h43, "ctl");
        io(1'b1, 3'h1, 8'h00, "");
        io(1'b0, 3'h1, 8'h00, "flag");
        chk("irq", 8'h00, {7'h0, irq});
        io(1'b1, 3'h1, 8'h01, "");
        io(1'b1, 3'h3, 8'h80, "");
        io(1'b0, 3'h1, 8'h01, "flag");
        chk("irq", 8'h00, {7'h0, irq});
        @(posedge clk);
        sleeping <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("wake", 8'h01, {7'h0, wake});
        io(1'b0, 3'h0, 8'h43, "ctl");
        $display("flag done");
        io(1'b1, 3'h5, 8'h07, "");
        io(1'b1, 3'h0, 8'h06, "");
        repeat (2) @(posedge clk);
        #1 chk("oe", 8'h18, {3'h0, pin_oe});
        io(1'b0, 3'h4, exp_port(cmpi_pkg::MODE_PIN_OUT, 5'h0f), "port");
        seed = xs(seed);
        io(1'b1, 3'h6, {3'h0, seed[4:0]}, "");
        io(1'b0, 3'h6, {3'h0, seed[4:0]}, "pout");
        chk("pin_out", {3'h0, seed[4:0]}, {3'h0, pin_out});
        $display("pins done");
        summarize();
    end
endmodule
`default_nettype wire
